// *** pgs_supervisor.sv ***
// power-good, thermal and stack start-up supervisor: package and top module
// assumes analog comparators and pin sensors feed async levels; AXI4-Lite master on aclk
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
package pgs_pkg;
   localparam int        CLK_HZ            = 20_000_000;
   localparam int        INIT_US           = 400;
   localparam int        INIT_CYCLES       = INIT_US * (CLK_HZ / 1_000_000);
   localparam int        DEGLITCH_US       = 40;
   localparam int        DEGLITCH_CYCLES   = DEGLITCH_US * (CLK_HZ / 1_000_000);
   localparam int        CNT_W             = 14;
   localparam int        ADDR_W            = 8;
   localparam logic [7:0] ADDR_FIRST_CONTROL_REGISTER    = 8'h00;
   localparam logic [7:0] ADDR_THIRD_CONTROL_REGISTER    = 8'h04;
   localparam logic [7:0] ADDR_STATUS      = 8'h08;
   localparam logic [7:0] ADDR_STATE       = 8'h0C;
   // first_control_register fields
   localparam int        DISCH_BIT         = 0;
   localparam int        SWEN_BIT          = 1;
   localparam int        FPWM_BIT          = 2;
   localparam logic [2:0] FIRST_CONTROL_REGISTER_RESET   = 3'h3;
   // third_control_register fields
   localparam int        BLANK_BIT         = 0;
   localparam int        SINGLE_BIT        = 1;
   localparam logic [1:0] THIRD_CONTROL_REGISTER_RESET   = 2'h0;
   // status fields
   localparam int        WARN_BIT          = 0;
   localparam int        SHUT_BIT          = 1;
   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;
   typedef enum logic [1:0] {
      ST_INIT    = 2'b00,
      ST_STANDBY = 2'b01,
      ST_SOFT    = 2'b10,
      ST_ON      = 2'b11
   } pgs_state_t;
   // asynchronous levels from the analog side and the shared pins
   typedef struct packed {
      logic vout_low;         // output below 95 % of setpoint
      logic vout_high;        // output above 105 % of setpoint
      logic temp_over_130;
      logic temp_over_150;
      logic temp_over_170;
      logic uvlo;
      logic soft_start_done;
      logic ramp_active;      // voltage_ramp_transition in progress
      logic enable_line;      // level of the shared enable wire
      logic power_good_line;  // level of the shared power-good wire
      logic sync_out_high;    // clock-output pin level sensed during init
   } pgs_sense_t;
   // pin and converter controls, open-drain enables are active low
   typedef struct packed {
      logic power_good_oe_n;
      logic enable_oe_n;
      logic comp_hold_oe_n;
      logic comp_drive;
      logic switching_on;
      logic soft_start_req;
      logic discharge_on;
      logic ccm_mode;
      logic forced_pwm;
      logic clock_from_chain;
      logic role_secondary;
   } pgs_drive_t;
endpackage : pgs_pkg

module pgs_supervisor #(
   parameter int INIT_LEN = pgs_pkg::INIT_CYCLES
) (
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   input  wire pgs_pkg::pgs_sense_t        sense,
   output      pgs_pkg::pgs_drive_t        drive,
   input  wire logic                       awvalid,
   output      logic                       awready,
   input  wire logic [pgs_pkg::ADDR_W-1:0] awaddr,
   input  wire logic                       wvalid,
   output      logic                       wready,
   input  wire logic [31:0]                wdata,
   input  wire logic [3:0]                 wstrb,
   output      logic                       bvalid,
   input  wire logic                       bready,
   output      logic [1:0]                 bresp,
   input  wire logic                       arvalid,
   output      logic                       arready,
   input  wire logic [pgs_pkg::ADDR_W-1:0] araddr,
   output      logic                       rvalid,
   input  wire logic                       rready,
   output      logic [31:0]                rdata,
   output      logic [1:0]                 rresp
);
   import pgs_pkg::*;

   localparam int SW = $bits(pgs_sense_t);

   // three-stage synchroniser; a change counts once stages two and three agree
   logic [SW-1:0] sync1, sync2, sync3, filt;
   pgs_sense_t    s;
   assign s = pgs_sense_t'(filt);

   always_ff @(posedge aclk) begin
      sync1 <= sense;
      sync2 <= sync1;
      sync3 <= sync2;
      if (!aresetn) begin
         filt <= '0;
      end else begin
         filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
      end
   end

   // register file
   logic [2:0]  first_control_register;
   logic [1:0]  third_control_register;
   logic        thermal_warning_flag;
   logic        thermal_shutdown_flag;
   logic [ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        aw_got, w_got;
   logic        status_read;

   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == ADDR_FIRST_CONTROL_REGISTER) || (a == ADDR_THIRD_CONTROL_REGISTER) ||
               (a == ADDR_STATUS) || (a == ADDR_STATE);
   endfunction : mapped

   assign status_read = arvalid && arready && (araddr == ADDR_STATUS);

   // write address and data may arrive in either order; answer when both held
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         aw_got  <= 1'b0;
         w_got   <= 1'b0;
         aw_addr <= '0;
         w_data  <= '0;
         w_strb  <= '0;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            aw_got  <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready) begin
            w_data <= wdata;
            w_strb <= wstrb;
            w_got  <= 1'b1;
            wready <= 1'b0;
         end
         if (aw_got && w_got && !bvalid) begin
            bvalid <= 1'b1;
            bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            aw_got  <= 1'b0;
            w_got   <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // stores happen in the cycle the response is raised
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         first_control_register <= FIRST_CONTROL_REGISTER_RESET;
         third_control_register <= THIRD_CONTROL_REGISTER_RESET;
      end else if (aw_got && w_got && !bvalid && w_strb[0]) begin
         if (aw_addr == ADDR_FIRST_CONTROL_REGISTER) begin
            first_control_register <= w_data[2:0];
         end
         if (aw_addr == ADDR_THIRD_CONTROL_REGISTER) begin
            third_control_register <= w_data[1:0];
         end
      end
   end

   // sequencing state
   pgs_state_t          state;
   logic [CNT_W-1:0]    init_cnt;
   logic                secondary;
   logic                in_shutdown;
   logic                enabled_once;
   logic                run_ok;
   logic                conduction_mode_flop;
   logic                pulldown_hold_flop;
   logic                line_prev;

   assign run_ok = s.enable_line && first_control_register[SWEN_BIT] && !in_shutdown && !s.uvlo;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state        <= ST_INIT;
         init_cnt     <= '0;
         secondary    <= 1'b0;
         enabled_once <= 1'b0;
      end else begin
         unique case (state)
            ST_INIT: begin
               init_cnt <= init_cnt + 1'b1;
               if (init_cnt == CNT_W'(INIT_LEN - 1)) begin
                  secondary <= !s.sync_out_high;
                  state     <= ST_STANDBY;
               end
            end
            ST_STANDBY: begin
               if (run_ok) begin
                  state        <= ST_SOFT;
                  enabled_once <= 1'b1;
               end
            end
            ST_SOFT: begin
               if (!run_ok) begin
                  state <= ST_STANDBY;
               end else if (s.soft_start_done) begin
                  state <= ST_ON;
               end
            end
            ST_ON: begin
               if (!run_ok) begin
                  state <= ST_STANDBY;
               end
            end
         endcase
      end
   end

   // shutdown with hysteresis: enter above 170 C, leave below 150 C
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_shutdown <= 1'b0;
      end else if (s.temp_over_170) begin
         in_shutdown <= 1'b1;
      end else if (!s.temp_over_150) begin
         in_shutdown <= 1'b0;
      end
   end

   // sticky flags; a set in the same cycle as a clearing read wins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thermal_warning_flag <= 1'b0;
      end else if (s.temp_over_150) begin
         thermal_warning_flag <= 1'b1;
      end else if (status_read && !s.temp_over_130) begin
         thermal_warning_flag <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         thermal_shutdown_flag <= 1'b0;
      end else if (s.temp_over_170) begin
         thermal_shutdown_flag <= 1'b1;
      end else if (status_read && !s.temp_over_150) begin
         thermal_shutdown_flag <= 1'b0;
      end
   end

   // window comparator and counter deglitch
   logic                window_fault;
   logic                fault_deg;
   logic [CNT_W-1:0]    deg_cnt;

   // during a blanked ramp the comparator reads as in-window
   assign window_fault = (s.vout_low || s.vout_high) &&
                         !(third_control_register[BLANK_BIT] && s.ramp_active);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fault_deg <= 1'b1;
         deg_cnt   <= '0;
      end else if (window_fault == fault_deg) begin
         deg_cnt <= '0;
      end else if (deg_cnt == CNT_W'(DEGLITCH_CYCLES - 1)) begin
         fault_deg <= window_fault;
         deg_cnt   <= '0;
      end else begin
         deg_cnt <= deg_cnt + 1'b1;
      end
   end

   // secondary mode flops: both preset at init and at each new start-up
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         conduction_mode_flop <= 1'b1;
         pulldown_hold_flop   <= 1'b1;
         line_prev            <= 1'b0;
      end else begin
         line_prev <= s.power_good_line;
         if (state == ST_INIT || state == ST_STANDBY) begin
            conduction_mode_flop <= 1'b1;
            pulldown_hold_flop   <= 1'b1;
         end else begin
            if (state == ST_ON) begin
               pulldown_hold_flop <= 1'b0;
            end
            // rising edge of the shared line means the whole stack finished
            if (!pulldown_hold_flop && s.power_good_line && !line_prev) begin
               conduction_mode_flop <= 1'b0;
            end
         end
      end
   end

   // pin and converter drive, all registered
   logic primary_release;
   logic fault_any;
   logic disabled;
   assign disabled  = !s.enable_line || !first_control_register[SWEN_BIT];
   assign fault_any = in_shutdown || s.uvlo;
   assign primary_release = (state == ST_ON) && !fault_any && !disabled &&
                            !fault_deg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drive <= '{power_good_oe_n: 1'b0, enable_oe_n: 1'b0, comp_hold_oe_n: 1'b0,
                    comp_drive: 1'b0, switching_on: 1'b0, soft_start_req: 1'b0,
                    discharge_on: 1'b0, ccm_mode: 1'b0, forced_pwm: 1'b0,
                    clock_from_chain: 1'b0, role_secondary: 1'b0};
      end else begin
         if (state == ST_INIT) begin
            drive.power_good_oe_n <= 1'b0;
         end else if (secondary) begin
            drive.power_good_oe_n <= !pulldown_hold_flop;
         end else begin
            drive.power_good_oe_n <= primary_release;
         end
         // init always pulls; faults pull only when part of a stack
         drive.enable_oe_n <= !(state == ST_INIT ||
                                (fault_any && !third_control_register[SINGLE_BIT]));
         drive.comp_hold_oe_n   <= secondary || s.enable_line;
         drive.comp_drive       <= !secondary && s.enable_line && state != ST_INIT;
         drive.switching_on     <= (state == ST_SOFT || state == ST_ON) && run_ok;
         drive.soft_start_req   <= (state == ST_STANDBY) && run_ok;
         drive.discharge_on     <= enabled_once && (disabled || fault_any) &&
                                   (first_control_register[DISCH_BIT] || secondary);
         drive.ccm_mode         <= secondary ? !conduction_mode_flop : 1'b1;
         drive.forced_pwm       <= secondary || first_control_register[FPWM_BIT];
         drive.clock_from_chain <= secondary;
         drive.role_secondary   <= secondary;
      end
   end

   // read channel; reading status is what clears the thermal flags
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= '0;
         rresp   <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rresp   <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
         unique case (araddr)
            ADDR_FIRST_CONTROL_REGISTER: rdata <= {29'h0, first_control_register};
            ADDR_THIRD_CONTROL_REGISTER: rdata <= {30'h0, third_control_register};
            ADDR_STATUS:   rdata <= {30'h0, thermal_shutdown_flag, thermal_warning_flag};
            ADDR_STATE:    rdata <= {24'h0, fault_deg, in_shutdown, conduction_mode_flop,
                                     pulldown_hold_flop, secondary, drive.power_good_oe_n,
                                     state};
            default:       rdata <= 32'h0;
         endcase
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end
endmodule : pgs_supervisor

// *** pgs_supervisor_properties.sv ***
// assertion checker for the supervisor: power-good, stack pins and thermal reaction
// assumes it is bound to pgs_supervisor and sees only its ports
`timescale 1ns/1ps
module pgs_properties
   import pgs_pkg::*;
(
   input wire logic       aclk,
   input wire logic       aresetn,
   input wire pgs_sense_t sense,
   input wire pgs_drive_t drive
);
   int unsigned quiet;
   // raw quiet time; the design sees faults a few cycles late, hence the slack below 800
   always_ff @(posedge aclk) begin
      if (!aresetn || ((sense.vout_low || sense.vout_high) && !sense.ramp_active)) begin
         quiet <= 0;
      end else if (quiet < 2000) begin
         quiet <= quiet + 1;
      end
   end
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   init_pg_pull_a : assert property ($rose(aresetn) |-> !drive.power_good_oe_n [*8])
      else $error("power-good released during init");
   init_en_pull_a : assert property ($rose(aresetn) |-> !drive.enable_oe_n [*8])
      else $error("enable released during init");
   pg_deglitch_a : assert property (!drive.role_secondary && $rose(drive.power_good_oe_n)
      |-> quiet >= 790)
      else $error("power-good rose before the deglitch time");
   hot_stop_a : assert property (sense.temp_over_170 [*7]
      |-> !drive.power_good_oe_n && !drive.switching_on)
      else $error("shutdown left power-good or switching on");
   lockout_pg_a : assert property ((!drive.role_secondary && sense.uvlo) [*7]
      |-> !drive.power_good_oe_n)
      else $error("power-good released in lockout");
   comp_hold_a : assert property ((!drive.role_secondary && !sense.enable_line) [*7]
      |-> !drive.comp_drive && !drive.comp_hold_oe_n)
      else $error("comp node not held while enable low");
   ccm_after_pg_a : assert property (drive.role_secondary && $rose(drive.ccm_mode)
      |-> $past(sense.power_good_line, 3))
      else $error("continuous mode without power-good rise");
   sec_fpwm_a : assert property (drive.role_secondary |-> drive.forced_pwm)
      else $error("secondary not in forced fixed frequency");
   chain_clock_a : assert property (drive.clock_from_chain == drive.role_secondary)
      else $error("clock source differs from role");
   soft_start_first_a : assert property ($rose(drive.switching_on)
      |-> $past(drive.soft_start_req))
      else $error("switching began without a soft start request");
endmodule : pgs_properties

bind pgs_supervisor pgs_properties u_pgs_properties (
   .aclk    (aclk),
   .aresetn (aresetn),
   .sense   (sense),
   .drive   (drive)
);

// *** pgs_stack_model.sv ***
// model of the far side: other stack members on shared lines and the converter ramp
// assumes the bench sets analog levels; shared lines carry pull-ups
`timescale 1ns/1ps
module pgs_stack_model
   import pgs_pkg::*;
(
   input  wire logic       aclk,
   input  wire pgs_drive_t drive,
   input  wire logic       en_hold,
   input  wire logic       pg_hold,
   input  wire logic       has_resistor,
   input  wire logic [5:0] analog,
   input  wire logic       ramp,
   output      pgs_sense_t sense
);
   int ss_cnt = 0;
   logic en_line;
   logic pg_line;
   // soft start finishes some time after switching starts
   always @(posedge aclk) ss_cnt <= drive.switching_on ? ss_cnt + (ss_cnt < 30) : 0;
   assign en_line = drive.enable_oe_n & !en_hold;
   assign pg_line = drive.power_good_oe_n & !pg_hold;
   // hiccup protection is never modelled: members stay in current limit only
   assign sense = {analog, ss_cnt >= 30, ramp, en_line, pg_line, !has_resistor};
endmodule : pgs_stack_model

// *** pgs_supervisor_tb.sv ***
// self-checking bench: register bus, power-good, thermal and stack start-up
// assumes pgs_stack_model stands in for the analog side and the other members
`timescale 1ns/1ps
module pgs_supervisor_tb;
   import pgs_pkg::*;
   localparam int PGO = 10;
   localparam int ENO = 9;
   localparam int CCM = 3;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, en_hold = 1, pg_hold = 0, res = 0, ramp = 0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic [1:0] bresp, rresp;
   logic [5:0] analog = 6'h00;
   pgs_sense_t sense;
   pgs_drive_t drive;
   int compares = 0, miscompares = 0, n, g;
   logic exp_warn = 0, exp_shut = 0;

   always #25 aclk = ~aclk;

   pgs_supervisor #(.INIT_LEN(16)) u_pgs_supervisor (.aclk(aclk), .aresetn(aresetn),
      .sense(sense), .drive(drive), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));
   pgs_stack_model u_pgs_stack_model (.aclk(aclk), .drive(drive), .en_hold(en_hold),
      .pg_hold(pg_hold), .has_resistor(res), .analog(analog), .ramp(ramp), .sense(sense));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic conclude;
      $display("comparisons %0d mismatches %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      {awvalid, wvalid, bready, wstrb} <= {3'h7, 4'hF};
      awaddr <= a;
      wdata <= d;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 0;
         if (wready) wvalid <= 0;
      end while (!bvalid);
      bready <= 0;
      check("bresp", bresp, er);
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      @(posedge aclk);
      {arvalid, rready} <= 2'h3;
      araddr <= a;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 0;
      end while (!rvalid);
      rready <= 0;
      check("rdata", rdata, exp);
      check("rresp", rresp, er);
   endtask : axr

   // status model: flags set by heat, read clears only when cool enough
   task automatic stat;
      axr(ADDR_STATUS, {exp_shut, exp_warn}, RESP_OKAY);
      if (!analog[3]) exp_warn = 0;
      if (!analog[2]) exp_shut = 0;
   endtask : stat

   task automatic temps(input logic [5:0] v);
      @(posedge aclk) analog <= v;
      repeat (12) @(negedge aclk);
      if (v[2]) exp_warn = 1;
      if (v[1]) exp_shut = 1;
   endtask : temps

   task automatic waitbit(input int b, input logic v, input int lim);
      n = 0;
      while (drive[b] !== v && n < lim) begin
         @(negedge aclk);
         n++;
      end
      check("drive bit", drive[b], v);
   endtask : waitbit

   initial begin
      repeat (40000) @(posedge aclk);
      miscompares++;
      conclude();
   end

   initial begin
      void'($urandom(64));
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      repeat (2) @(negedge aclk);
      check("pg init", drive.power_good_oe_n, 1'h0);
      check("en init", drive.enable_oe_n, 1'h0);
      axr(ADDR_FIRST_CONTROL_REGISTER, 32'h3, RESP_OKAY);
      axr(ADDR_THIRD_CONTROL_REGISTER, 32'h0, RESP_OKAY);
      axr(8'h10, 32'h0, RESP_SLVERR);
      axw(8'h10, 32'h1, RESP_SLVERR);
      axw(ADDR_FIRST_CONTROL_REGISTER, 32'h7, RESP_OKAY);
      axw(ADDR_THIRD_CONTROL_REGISTER, 32'h1, RESP_OKAY);
      axr(ADDR_THIRD_CONTROL_REGISTER, 32'h1, RESP_OKAY);
      repeat (20) @(negedge aclk);
      check("comp held", {drive.comp_hold_oe_n, drive.comp_drive}, 2'h0);
      check("fpwm", drive.forced_pwm, 1'h1);
      @(posedge aclk) en_hold <= 0;
      for (int b = 5; b >= 4; b--) begin
         waitbit(PGO, 1, 4000);
         check("comp drive", drive.comp_drive, 1'h1);
         g = 1 + $urandom % 600;
         @(posedge aclk) analog[b] <= 1;
         repeat (g) @(posedge aclk);
         analog[b] <= 0;
         repeat (900) @(negedge aclk);
         check("glitch", drive.power_good_oe_n, 1'h1);
         @(posedge aclk) analog[b] <= 1;
         waitbit(PGO, 0, 2000);
         check("deglitch", n >= 800 && n <= 812, 1'h1);
         @(posedge aclk) analog[b] <= 0;
      end
      waitbit(PGO, 1, 2000);
      @(posedge aclk) {ramp, analog} <= 7'h50;
      repeat (1000) @(negedge aclk);
      check("blanked", drive.power_good_oe_n, 1'h1);
      @(posedge aclk) {ramp, analog} <= 7'h00;
      temps(6'h0C);
      stat();
      temps(6'h08);
      stat();
      temps(6'h00);
      stat();
      stat();
      temps(6'h0E);
      check("hot", {drive[PGO], drive[ENO], drive.switching_on, drive.discharge_on}, 4'h1);
      stat();
      temps(6'h0C);
      check("still hot", drive.enable_oe_n, 1'h0);
      stat();
      temps(6'h00);
      waitbit(ENO, 1, 50);
      stat();
      stat();
      waitbit(PGO, 1, 4000);
      axw(ADDR_THIRD_CONTROL_REGISTER, 32'h3, RESP_OKAY);
      temps(6'h01);
      check("lockout", drive.power_good_oe_n, 1'h0);
      check("single en", drive.enable_oe_n, 1'h1);
      temps(6'h00);
      @(posedge aclk) {aresetn, res, pg_hold} <= 3'h3;
      repeat (20) @(posedge aclk);
      aresetn <= 1;
      {exp_warn, exp_shut} = 2'h0;
      @(negedge aclk);
      waitbit(0, 1, 100);
      check("sec pulls", {drive[PGO], drive[CCM]}, 2'h0);
      check("sec fpwm", {drive.forced_pwm, drive.clock_from_chain}, 2'h3);
      waitbit(PGO, 1, 300);
      repeat (20) @(negedge aclk);
      check("dcm held", drive[CCM], 1'h0);
      @(posedge aclk) pg_hold <= 0;
      waitbit(CCM, 1, 20);
      conclude();
   end
endmodule : pgs_supervisor_tb
